// ---- wtd_params.svh ----
`ifndef WTD_PARAMS_SVH
`define WTD_PARAMS_SVH

// Register offsets
`define WTD_OFF_CONTROL      8'h23
`define WTD_OFF_RELOAD_HIGH  8'h24
`define WTD_OFF_RELOAD_LOW   8'h25
`define WTD_OFF_COUNT_HIGH   8'h26
`define WTD_OFF_COUNT_LOW    8'h27
`define WTD_OFF_DRIVE_SETUP  8'h28
`define WTD_OFF_AMP_SETUP    8'h29

// Control register fields
`define WTD_CTL_RUNNING_BIT  7
`define WTD_CTL_QUALIFY_BIT  6

// Drive setup fields
`define WTD_DRV_INV2_BIT     7
`define WTD_DRV_INV1_BIT     6
`define WTD_DRV_ENABLE_BIT   3
`define WTD_DRV_STYLE_MSB    2
`define WTD_DRV_STYLE_LSB    0
`define WTD_DRV_WRITE_MASK   8'hCF

// Amplitude setup fields
`define WTD_AMP_TRIM_MSB     7
`define WTD_AMP_TRIM_LSB     6
`define WTD_AMP_RESID_MSB    4
`define WTD_AMP_RESID_LSB    0
`define WTD_AMP_WRITE_MASK   8'hDF

// Reset values and unmapped read data
`define WTD_RST_BYTE         8'h00
`define WTD_RST_COUNT        16'h0000
`define WTD_UNMAPPED_DATA    8'h00

`endif

// ---- wtd_pkg.sv ----
`default_nettype none
package wtd_pkg;

   typedef enum logic [2:0] {
      WTD_DRV_HIZ        = 3'b000,
      WTD_DRV_OPEN_DRAIN = 3'b001,
      WTD_DRV_PUSH_PULL  = 3'b010,
      WTD_DRV_FIXED_LOW  = 3'b100,
      WTD_DRV_FIXED_HIGH = 3'b101
   } wtd_drive_e;

   typedef struct packed {
      logic        running;
      logic [15:0] count;
   } wtd_count_s;

   typedef struct packed {
      logic       ctl_start;
      logic       ctl_stop;
      logic [7:0] reload_high;
      logic [7:0] reload_low;
      logic [7:0] drive_setup;
      logic [7:0] amp_setup;
      logic [7:0] rdata;
      logic       tx1_out;
      logic       tx1_oe;
      logic       tx2_out;
      logic       tx2_oe;
      logic [1:0] trim;
      logic       max_drive;
      logic [4:0] residual;
      logic       running;
   } wtd_state_s;

endpackage
`default_nettype wire

// ---- wtd_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface wtd_timer_if;
   logic        start;
   logic        stop;
   logic [15:0] reload;
   logic [15:0] count;
   logic        running;

   modport ctrl (output start, output stop, output reload, input count, input running);
   modport timer (input start, input stop, input reload, output count, output running);
endinterface
`default_nettype wire

// ---- wtd_wake_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wtd_params.svh"
module wtd_wake_counter
   import wtd_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     reset,
   input  wire logic     clk_en,
   input  wire logic     wake_tick,
   wtd_timer_if.timer    tif
);

   wtd_count_s st;
   wtd_count_s next_st;

   always_comb
   begin
      next_st = st;
      if (tif.start)
      begin
         next_st.count   = tif.reload;
         next_st.running = 1'b1;
      end
      else if (tif.stop)
      begin
         next_st.running = 1'b0;
      end
      else if (st.running && wake_tick)
      begin
         if (st.count == `WTD_RST_COUNT)
         begin
            next_st.running = 1'b0;
         end
         else
         begin
            next_st.count = st.count - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   assign tif.count   = st.count;
   assign tif.running = st.running;

   ////////////////////////////////////////////////////////////////////////
   a_reload_load_start:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && tif.start) |=> (st.count == $past(tif.reload)) && st.running)
      else $error("Counter did not load reload value at start");

   a_reload_no_disturb:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && !tif.start && !wake_tick) |=> $stable(st.count))
      else $error("Count changed without start or tick");

endmodule
`default_nettype wire

// ---- wtd_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wtd_params.svh"
////////////////////////////////////////////////////////////////////////////
// Function
// - Writable reload low byte register
// - Writable reload high byte register
// - Start loads counter from combined reload
// - Reload writes affect only next start
// - Start/stop only with running plus qualifier
// - Read-only live count high byte
// - Read-only live count low byte
// - Bit 7 inverts second output
// - Bit 6 inverts first output
// - Bit 3 enables both outputs
// - Style field selects output drive manner
// - Two-bit carrier level reduction select
// - Full-carrier override forces maximum, ignores trim
// - Five-bit residual carrier setting passed on
module wtd_regs
   import wtd_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       wake_tick,
   input  wire logic       carrier_in,
   input  wire logic       full_carrier_override,
   output logic            first_antenna_output_out,
   output logic            first_antenna_output_oe,
   output logic            second_antenna_output_out,
   output logic            second_antenna_output_oe,
   output logic      [1:0] carrier_level_trim,
   output logic            carrier_max_drive,
   output logic      [4:0] residual_carrier,
   output logic            wake_timer_running
);

   wtd_state_s st;
   wtd_state_s next_st;
   wtd_timer_if tif ();

   logic       drv1;
   logic       drv2;
   logic       enable;
   wtd_drive_e style;

   ////////////////////////////////////////////////////////////////////////
   // Wake-up counter
   wtd_wake_counter u_counter (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .wake_tick (wake_tick),
      .tif       (tif.timer)
   );

   assign tif.start  = st.ctl_start;
   assign tif.stop   = st.ctl_stop;
   assign tif.reload = {st.reload_high, st.reload_low};

   ////////////////////////////////////////////////////////////////////////
   // Drive signal path
   assign enable = st.drive_setup[`WTD_DRV_ENABLE_BIT];
   assign style  = wtd_drive_e'(st.drive_setup[`WTD_DRV_STYLE_MSB:`WTD_DRV_STYLE_LSB]);
   assign drv1   = carrier_in ^ st.drive_setup[`WTD_DRV_INV1_BIT];
   assign drv2   = carrier_in ^ st.drive_setup[`WTD_DRV_INV2_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.ctl_start = 1'b0;
      next_st.ctl_stop  = 1'b0;
      next_st.rdata     = `WTD_UNMAPPED_DATA;
      next_st.running   = tif.running;

      // Register writes
      if (reg_wr)
      begin
         unique case (reg_addr)
            `WTD_OFF_CONTROL:
            begin
               if (reg_wdata[`WTD_CTL_QUALIFY_BIT])
               begin
                  next_st.ctl_start = reg_wdata[`WTD_CTL_RUNNING_BIT];
                  next_st.ctl_stop  = !reg_wdata[`WTD_CTL_RUNNING_BIT];
               end
            end
            `WTD_OFF_RELOAD_HIGH:
            begin
               next_st.reload_high = reg_wdata;
            end
            `WTD_OFF_RELOAD_LOW:
            begin
               next_st.reload_low = reg_wdata;
            end
            `WTD_OFF_DRIVE_SETUP:
            begin
               next_st.drive_setup = reg_wdata & `WTD_DRV_WRITE_MASK;
            end
            `WTD_OFF_AMP_SETUP:
            begin
               next_st.amp_setup = reg_wdata & `WTD_AMP_WRITE_MASK;
            end
            default:
            begin
               next_st.reload_low = st.reload_low;
            end
         endcase
      end

      // Register reads, data in the following cycle
      if (reg_rd)
      begin
         unique case (reg_addr)
            `WTD_OFF_CONTROL:
            begin
               next_st.rdata = {st.running, 7'h00};
            end
            `WTD_OFF_RELOAD_HIGH:
            begin
               next_st.rdata = st.reload_high;
            end
            `WTD_OFF_RELOAD_LOW:
            begin
               next_st.rdata = st.reload_low;
            end
            `WTD_OFF_COUNT_HIGH:
            begin
               next_st.rdata = tif.count[15:8];
            end
            `WTD_OFF_COUNT_LOW:
            begin
               next_st.rdata = tif.count[7:0];
            end
            `WTD_OFF_DRIVE_SETUP:
            begin
               next_st.rdata = st.drive_setup;
            end
            `WTD_OFF_AMP_SETUP:
            begin
               next_st.rdata = st.amp_setup;
            end
            default:
            begin
               next_st.rdata = `WTD_UNMAPPED_DATA;
            end
         endcase
      end

      // Transmitter outputs
      next_st.tx1_out = 1'b0;
      next_st.tx1_oe  = 1'b0;
      next_st.tx2_out = 1'b0;
      next_st.tx2_oe  = 1'b0;
      if (enable)
      begin
         unique case (style)
            WTD_DRV_OPEN_DRAIN:
            begin
               next_st.tx1_oe = !drv1;
               next_st.tx2_oe = !drv2;
            end
            WTD_DRV_PUSH_PULL:
            begin
               next_st.tx1_out = drv1;
               next_st.tx1_oe  = 1'b1;
               next_st.tx2_out = drv2;
               next_st.tx2_oe  = 1'b1;
            end
            WTD_DRV_FIXED_LOW:
            begin
               next_st.tx1_oe = 1'b1;
               next_st.tx2_oe = 1'b1;
            end
            WTD_DRV_FIXED_HIGH:
            begin
               next_st.tx1_out = 1'b1;
               next_st.tx1_oe  = 1'b1;
               next_st.tx2_out = 1'b1;
               next_st.tx2_oe  = 1'b1;
            end
            WTD_DRV_HIZ:
            begin
               next_st.tx1_oe = 1'b0;
               next_st.tx2_oe = 1'b0;
            end
            default:
            begin
               // Unsupported codes leave both pins released
               next_st.tx1_oe = 1'b0;
               next_st.tx2_oe = 1'b0;
            end
         endcase
      end

      // Amplitude settings
      if (full_carrier_override)
      begin
         next_st.trim      = 2'h0;
         next_st.max_drive = 1'b1;
      end
      else
      begin
         next_st.trim      = st.amp_setup[`WTD_AMP_TRIM_MSB:`WTD_AMP_TRIM_LSB];
         next_st.max_drive = 1'b0;
      end
      next_st.residual = st.amp_setup[`WTD_AMP_RESID_MSB:`WTD_AMP_RESID_LSB];
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   assign reg_rdata                 = st.rdata;
   assign first_antenna_output_out  = st.tx1_out;
   assign first_antenna_output_oe   = st.tx1_oe;
   assign second_antenna_output_out = st.tx2_out;
   assign second_antenna_output_oe  = st.tx2_oe;
   assign carrier_level_trim        = st.trim;
   assign carrier_max_drive         = st.max_drive;
   assign residual_carrier          = st.residual;
   assign wake_timer_running        = st.running;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_reload_low_write:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_wr && reg_addr == `WTD_OFF_RELOAD_LOW)
      |=> st.reload_low == $past(reg_wdata))
      else $error("Reload low byte not stored");

   a_reload_high_write:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_wr && reg_addr == `WTD_OFF_RELOAD_HIGH)
      |=> st.reload_high == $past(reg_wdata))
      else $error("Reload high byte not stored");

   a_start_needs_qualifier:
   assert property (@(posedge ref_clk) disable iff (reset)
      ($rose(st.ctl_start) || $rose(st.ctl_stop))
      |-> $past(reg_wr && reg_addr == `WTD_OFF_CONTROL && reg_wdata[`WTD_CTL_QUALIFY_BIT]))
      else $error("Start or stop without qualifier write");

   a_start_loads_count:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_wr && reg_addr == `WTD_OFF_CONTROL && reg_wdata[7:6] == 2'b11)
      ##1 clk_en |=> tif.count == $past(tif.reload) && tif.running)
      else $error("Qualified start did not load reload value");

   a_count_high_read:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == `WTD_OFF_COUNT_HIGH)
      |=> reg_rdata == $past(tif.count[15:8]))
      else $error("Count high byte read mismatch");

   a_count_low_read:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == `WTD_OFF_COUNT_LOW)
      |=> reg_rdata == $past(tif.count[7:0]))
      else $error("Count low byte read mismatch");

   a_second_invert:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && enable && style == WTD_DRV_PUSH_PULL)
      |=> second_antenna_output_out == ($past(carrier_in) ^ $past(st.drive_setup[7])))
      else $error("Second output inversion wrong");

   a_first_invert:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && enable && style == WTD_DRV_PUSH_PULL)
      |=> first_antenna_output_out == ($past(carrier_in) ^ $past(st.drive_setup[6])))
      else $error("First output inversion wrong");

   a_enable_gates_pins:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && !enable) |=> !first_antenna_output_oe && !second_antenna_output_oe)
      else $error("Pin driven while outputs disabled");

   a_open_drain_style:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && enable && style == WTD_DRV_OPEN_DRAIN)
      |=> !first_antenna_output_out && (first_antenna_output_oe == !$past(drv1)))
      else $error("Open drain drive wrong");

   a_trim_follows:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && !full_carrier_override)
      |=> carrier_level_trim == $past(st.amp_setup[7:6]) && !carrier_max_drive)
      else $error("Carrier trim not passed on");

   a_override_max:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && full_carrier_override) |=> carrier_max_drive && carrier_level_trim == 2'h0)
      else $error("Override did not force maximum");

   a_residual_pass:
   assert property (@(posedge ref_clk) disable iff (reset)
      clk_en |=> residual_carrier == $past(st.amp_setup[4:0]))
      else $error("Residual carrier not passed on");

   a_reserved_zero:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == `WTD_OFF_DRIVE_SETUP) |=> reg_rdata[5:4] == 2'h0)
      else $error("Reserved drive bits not zero");

   a_reserved_amp_zero:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && reg_rd && reg_addr == `WTD_OFF_AMP_SETUP)
      |=> (reg_rdata & ~`WTD_AMP_WRITE_MASK) == 8'h00)
      else $error("Reserved amplitude bit not zero");

   a_push_pull_drive:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && enable && style == WTD_DRV_PUSH_PULL)
      |=> first_antenna_output_oe && second_antenna_output_oe)
      else $error("Push-pull pins not driven");

   a_fixed_level_drive:
   assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && enable && (style == WTD_DRV_FIXED_LOW || style == WTD_DRV_FIXED_HIGH))
      |=> first_antenna_output_oe && second_antenna_output_oe
         && (first_antenna_output_out == $past(style == WTD_DRV_FIXED_HIGH))
         && (second_antenna_output_out == $past(style == WTD_DRV_FIXED_HIGH)))
      else $error("Fixed level drive wrong");

endmodule
`default_nettype wire

// ---- wtd_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wtd_pin_model
(
   input  wire logic drive_out,
   input  wire logic drive_oe,
   output logic      pin_level
);
   // Antenna pin with pull-up, released pin reads high
   assign pin_level = drive_oe ? drive_out : 1'b1;
endmodule
`default_nettype wire

// ---- tb_wake_timer_and_tx_driver_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_wake_timer_and_tx_driver_regs;
   logic       ref_clk, reset, clk_en, reg_wr, reg_rd, wake_tick, carrier_in, full_carrier_override;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic       p1_out, p1_oe, p2_out, p2_oe, p1_lvl, p2_lvl, max_drv, running;
   logic [1:0] trim, e1, e2;
   logic [4:0] resid;
   int         error_cnt, total_checks;
   logic [2:0] styles [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   wtd_regs i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_tick(wake_tick), .carrier_in(carrier_in), .full_carrier_override(full_carrier_override),
      .first_antenna_output_out(p1_out), .first_antenna_output_oe(p1_oe),
      .second_antenna_output_out(p2_out), .second_antenna_output_oe(p2_oe),
      .carrier_level_trim(trim), .carrier_max_drive(max_drv), .residual_carrier(resid),
      .wake_timer_running(running));
   wtd_pin_model i_pin1 (.drive_out(p1_out), .drive_oe(p1_oe), .pin_level(p1_lvl));
   wtd_pin_model i_pin2 (.drive_out(p2_out), .drive_oe(p2_oe), .pin_level(p2_lvl));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic tick;
      @(posedge ref_clk);
      wake_tick <= 1'b1;
      @(posedge ref_clk);
      wake_tick <= 1'b0;
   endtask
   task automatic wait_run(input logic exp);
      #1;
      for (int i = 0; i < 8 && running !== exp; i++)
         cyc(1);
      if (running !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t running flag wait ran out", $time);
         final_report();
      end
   endtask
   // Returns {oe, pin level} for a style and drive value
   function automatic logic [1:0] pin_exp(input logic [2:0] s, input logic dr);
      case (s)
         3'h0:    return 2'h1;
         3'h1:    return {~dr, dr};
         3'h2:    return {1'b1, dr};
         3'h4:    return 2'h2;
         default: return 2'h3;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {reg_wr, reg_rd, wake_tick, carrier_in, full_carrier_override} = 5'h00;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      clk_en    = 1'b1;
      reset     = 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      // Reset values and unmapped address
      for (int a = 8'h23; a <= 8'h2A; a++)
      begin
         rdr(8'(a));
         check(rd, 8'h00, "reset value");
      end
      check({6'h00, p1_oe, p2_oe}, 8'h00, "reset pin enables");
      $display("test reset done");
      // Register access kinds
      wr(8'h24, 8'hA5);
      wr(8'h25, 8'h3C);
      wr(8'h28, 8'hF8);
      wr(8'h29, 8'hFF);
      wr(8'h2A, 8'h11);
      rdr(8'h24); check(rd, 8'hA5, "reload high");
      rdr(8'h25); check(rd, 8'h3C, "reload low");
      rdr(8'h28); check(rd, 8'hC8, "drive setup");
      rdr(8'h29); check(rd, 8'hDF, "amplitude setup");
      rdr(8'h2A); check(rd, 8'h00, "unmapped");
      $display("test access done");
      // Wake timer start, count, stop
      wr(8'h24, 8'h01);
      wr(8'h25, 8'h02);
      wr(8'h23, 8'hC0);
      wait_run(1'b1);
      rdr(8'h23); check(rd, 8'h80, "running bit after start");
      rdr(8'h26); check(rd, 8'h01, "count high after start");
      rdr(8'h27); check(rd, 8'h02, "count low after start");
      wr(8'h25, 8'h77);
      repeat (3) tick();
      rdr(8'h26); check(rd, 8'h00, "count high borrow");
      rdr(8'h27); check(rd, 8'hFF, "count low borrow");
      wr(8'h23, 8'h00);
      cyc(3);
      check({7'h00, running}, 8'h01, "write without qualifier");
      wr(8'h23, 8'h40);
      wait_run(1'b0);
      rdr(8'h23); check(rd, 8'h00, "running bit after stop");
      tick();
      rdr(8'h27); check(rd, 8'hFF, "stopped count");
      wr(8'h23, 8'h80);
      cyc(3);
      check({7'h00, running}, 8'h00, "start without qualifier");
      wr(8'h23, 8'hC0);
      wait_run(1'b1);
      wr(8'h27, 8'h55);
      rdr(8'h26); check(rd, 8'h01, "new reload high");
      rdr(8'h27); check(rd, 8'h77, "new reload low");
      @(posedge ref_clk);
      clk_en <= 1'b0;
      tick();
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rdr(8'h27); check(rd, 8'h77, "frozen count");
      // Restart from a short reload and count down to zero
      wr(8'h24, 8'h00);
      wr(8'h25, 8'h01);
      wr(8'h23, 8'hC0);
      wait_run(1'b1);
      repeat (2) tick();
      wait_run(1'b0);
      rdr(8'h26); check(rd, 8'h00, "count high at zero");
      rdr(8'h27); check(rd, 8'h00, "count low at zero");
      $display("test timer done");
      // Driver styles, inversions and enable
      foreach (styles[si])
         for (int m = 0; m < 4; m++)
            for (int c = 0; c < 2; c++)
            begin
               @(posedge ref_clk);
               carrier_in <= c[0];
               wr(8'h28, {m[1], m[0], 3'h1, styles[si]});
               cyc(2);
               e1 = pin_exp(styles[si], c[0] ^ m[0]);
               e2 = pin_exp(styles[si], c[0] ^ m[1]);
               check({6'h00, p1_oe, p1_lvl}, {6'h00, e1}, "first pin");
               check({6'h00, p2_oe, p2_lvl}, {6'h00, e2}, "second pin");
            end
      wr(8'h28, 8'hC2);
      cyc(2);
      check({6'h00, p1_oe, p2_oe}, 8'h00, "pins disabled");
      $display("test driver done");
      // Carrier level and residual setting, then override
      for (int t = 0; t < 4; t++)
      begin
         wr(8'h29, {t[1:0], 1'b1, 5'(t * 7 + 3)});
         cyc(2);
         check({6'h00, trim}, {6'h00, t[1:0]}, "trim");
         check({3'h0, resid}, 8'(t * 7 + 3), "residual");
         check({7'h00, max_drv}, 8'h00, "max drive off");
      end
      @(posedge ref_clk);
      full_carrier_override <= 1'b1;
      cyc(2);
      check({5'h00, max_drv, trim}, 8'h04, "override");
      check({3'h0, resid}, 8'h18, "residual under override");
      $display("test amplitude done");
      final_report();
   end
endmodule
`default_nettype wire
